// ===== verilog/acw_consts.svh
// register addresses, field positions, reset values for the compare window block
// assumes inclusion by bare name from the package and the top module
`ifndef ACW_CONSTS_SVH
`define ACW_CONSTS_SVH

// register byte addresses
`define ACW_EMR_ADDR 32'h4003_8040
`define ACW_WIN_ADDR 32'h4003_8044
`define ACW_LCR_ADDR 32'h4003_8020
`define ACW_IMR_ADDR 32'h4003_8024
`define ACW_ISR_ADDR 32'h4003_8030
`define ACW_WPR_ADDR 32'h4003_80E4

// extended mode field positions
`define ACW_MODE_LO 0
`define ACW_MODE_HI 1
`define ACW_SEL_LO 4
`define ACW_SEL_HI 7
`define ACW_ALL_BIT 9
`define ACW_TAG_BIT 24

// window threshold field positions
`define ACW_THR_LO_LO 0
`define ACW_THR_LO_HI 11
`define ACW_THR_HI_LO 16
`define ACW_THR_HI_HI 27

// last result field positions
`define ACW_LCR_DATA_HI 11
`define ACW_LCR_CH_LO 12
`define ACW_LCR_CH_HI 15

// status and mask bit positions
`define ACW_ST_DRDY 0
`define ACW_ST_CMP 1

// reset values
`define ACW_EMR_RST 32'h0000_0000
`define ACW_WIN_RST 32'h0000_0000
`define ACW_WPR_RST 1'b0
`define ACW_MSK_RST 2'h0

`endif

// ===== verilog/acw_pkg.sv
// types shared by the compare window block
// assumes the constants header sits next to it
package acw_pkg;
  `include "acw_consts.svh"

  // window condition encodings
  typedef enum logic [1:0] {
    ACW_BELOW = 2'h0,
    ACW_ABOVE = 2'h1,
    ACW_INSIDE = 2'h2,
    ACW_OUTSIDE = 2'h3
  } acw_cond_e;

  typedef logic [11:0] acw_sample_t;
  typedef logic [3:0] acw_chan_t;
endpackage

// ===== verilog/acw_top.sv
// converter extended mode registers, window compare and result tagging
// assumes a classic wishbone master on ref_clk and a converter core
// on the same clock that pulses conv_done with channel and sample;
// irq is a level from sticky status under its mask, cleared by a
// status read, and ineligible channels still update the last result
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
`include "acw_consts.svh"

module acw_top
  import acw_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic conv_done,
  input wire logic [3:0] conv_channel,
  input wire logic [11:0] conv_data,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////
  // register map, byte addresses in the constants header
  //   extended mode: [1:0] condition, [7:4] compared channel,
  //     [9] compare every channel, [24] channel tag on
  //   window: [11:0] low threshold, [27:16] high threshold
  //   last result (read only): [11:0] value, [15:12] channel
  //   mask: bit 0 conversion done, bit 1 compare hit
  //   status (read clears): same layout as the mask
  //   write protect: bit 0 only, no key, so any write with byte lane 0 enabled moves it
  // unmapped addresses still ack, read as zero and drop writes,
  // so a stray access never stalls the bus
  // the mode and window words keep all 32 bits so software reads back their value

  ////////////////////////////////////////////////////////////////////
  // helpers

  // full address match, used per register in the read decode and, for the four writable registers, in the write decode
  function automatic logic addr_hit(input logic [31:0] a,
                                    input logic [31:0] off);
    addr_hit = (a == off);
  endfunction

  // merge write data into a word under the byte enables
  function automatic logic [31:0] merge_sel(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    merge_sel = r;
  endfunction

  // threshold tests, shared by several window conditions
  function automatic logic below_low(input acw_sample_t v,
                                     input acw_sample_t lo);
    below_low = (v < lo);
  endfunction

  // strict on purpose: a value equal to a threshold is inside
  function automatic logic above_high(input acw_sample_t v,
                                      input acw_sample_t hi);
    above_high = (v > hi);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // state

  logic ack_reg;
  logic ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [31:0] converter_extended_mode_reg;
  logic [31:0] converter_extended_mode_next;
  logic [31:0] win_reg;
  logic [31:0] win_next;
  logic write_protect_on_reg;
  logic write_protect_on_next;
  // last result fields, filled on every completed conversion
  acw_sample_t lc_data_reg;
  acw_sample_t lc_data_next;
  acw_chan_t result_channel_number_reg;
  acw_chan_t result_channel_number_next;
  // sticky events and their mask share one bit layout
  logic [1:0] status_reg;
  logic [1:0] status_next;
  logic [1:0] mask_reg;
  logic [1:0] mask_next;

  // decoded bus strobes
  logic req;
  logic wr;
  logic rd;
  logic status_clear;

  // decoded configuration
  acw_cond_e window_condition_select;
  acw_chan_t compared_channel_number;
  logic compare_every_channel;
  logic tag_on;
  acw_sample_t thr_low;
  acw_sample_t thr_high;
  logic eligible;
  logic hit;

  ////////////////////////////////////////////////////////////////////
  // wishbone access decode

  // one access per request; ack_reg blocks a second take
  assign req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr = req && wb_we_i;
  assign rd = req && !wb_we_i;
  // status read clears at the take edge; a held request after its
  // ack is taken again, so software should not hold a status read
  assign status_clear = rd && addr_hit(wb_adr_i, `ACW_ISR_ADDR);

  // field views of the configuration registers
  assign window_condition_select =
    acw_cond_e'(converter_extended_mode_reg[`ACW_MODE_HI:`ACW_MODE_LO]);
  assign compared_channel_number =
    converter_extended_mode_reg[`ACW_SEL_HI:`ACW_SEL_LO];
  assign compare_every_channel = converter_extended_mode_reg[`ACW_ALL_BIT];
  assign tag_on = converter_extended_mode_reg[`ACW_TAG_BIT];
  assign thr_low = win_reg[`ACW_THR_LO_HI:`ACW_THR_LO_LO];
  assign thr_high = win_reg[`ACW_THR_HI_HI:`ACW_THR_HI_LO];

  ////////////////////////////////////////////////////////////////////
  // window comparison

  // channel eligibility and condition evaluation
  always_comb begin
    if (compare_every_channel) begin
      eligible = 1'b1;
    end else begin
      eligible = (conv_channel == compared_channel_number);
    end
    // strict below and above, so the window itself is inclusive
    case (window_condition_select)
      ACW_BELOW: hit = below_low(conv_data, thr_low);
      ACW_ABOVE: hit = above_high(conv_data, thr_high);
      ACW_INSIDE: hit = !below_low(conv_data, thr_low) &&
                        !above_high(conv_data, thr_high);
      ACW_OUTSIDE: hit = below_low(conv_data, thr_low) ||
                         above_high(conv_data, thr_high);
      default: hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // configuration registers

  // next values for mode, window, protect and mask
  always_comb begin
    converter_extended_mode_next = converter_extended_mode_reg;
    win_next = win_reg;
    write_protect_on_next = write_protect_on_reg;
    mask_next = mask_reg;
    if (wr) begin
      if (addr_hit(wb_adr_i, `ACW_EMR_ADDR)) begin
        if (!write_protect_on_reg) begin
          converter_extended_mode_next =
            merge_sel(converter_extended_mode_reg, wb_dat_i, wb_sel_i);
        end
      end else if (addr_hit(wb_adr_i, `ACW_WIN_ADDR)) begin
        win_next = merge_sel(win_reg, wb_dat_i, wb_sel_i);
      end else if (addr_hit(wb_adr_i, `ACW_WPR_ADDR)) begin
        // no key: a single bit write arms or lifts the lock
        if (wb_sel_i[0]) begin
          write_protect_on_next = wb_dat_i[0];
        end
      end else if (addr_hit(wb_adr_i, `ACW_IMR_ADDR)) begin
        if (wb_sel_i[0]) begin
          mask_next = wb_dat_i[1:0];
        end
      end
    end
  end

  // register the configuration
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      converter_extended_mode_reg <= `ACW_EMR_RST;
      win_reg <= `ACW_WIN_RST;
      write_protect_on_reg <= `ACW_WPR_RST;
      mask_reg <= `ACW_MSK_RST;
    end else begin
      converter_extended_mode_reg <= converter_extended_mode_next;
      win_reg <= win_next;
      write_protect_on_reg <= write_protect_on_next;
      mask_reg <= mask_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // last result and event status

  // capture result and raise sticky events; set beats read clear
  always_comb begin
    lc_data_next = lc_data_reg;
    result_channel_number_next = result_channel_number_reg;
    status_next = status_reg;
    if (status_clear) begin
      status_next = 2'h0;
    end
    // event applied after the clear, so a same-cycle set survives
    if (conv_done) begin
      lc_data_next = conv_data;
      if (tag_on) begin
        result_channel_number_next = conv_channel;
      end else begin
        result_channel_number_next = 4'h0;
      end
      status_next[`ACW_ST_DRDY] = 1'b1;
      if (eligible && hit) begin
        status_next[`ACW_ST_CMP] = 1'b1;
      end
    end
  end

  // register result and status
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      lc_data_reg <= 12'h000;
      result_channel_number_reg <= 4'h0;
      status_reg <= 2'h0;
    end else begin
      lc_data_reg <= lc_data_next;
      result_channel_number_reg <= result_channel_number_next;
      status_reg <= status_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // bus answer

  // read mux; unmapped addresses read zero and still ack
  always_comb begin
    rdata_next = 32'h0000_0000;
    ack_next = req;
    if (rd) begin
      if (addr_hit(wb_adr_i, `ACW_EMR_ADDR)) begin
        rdata_next = converter_extended_mode_reg;
      end else if (addr_hit(wb_adr_i, `ACW_WIN_ADDR)) begin
        rdata_next = win_reg;
      end else if (addr_hit(wb_adr_i, `ACW_WPR_ADDR)) begin
        rdata_next = {31'h0000_0000, write_protect_on_reg};
      end else if (addr_hit(wb_adr_i, `ACW_IMR_ADDR)) begin
        rdata_next = {30'h0000_0000, mask_reg};
      end else if (addr_hit(wb_adr_i, `ACW_ISR_ADDR)) begin
        rdata_next = {30'h0000_0000, status_reg};
      end else if (addr_hit(wb_adr_i, `ACW_LCR_ADDR)) begin
        rdata_next = {16'h0000, result_channel_number_reg, lc_data_reg};
      end
    end
  end

  // ack is high for exactly one cycle per request
  // registered ack: one cycle of latency, no path from stb to ack
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg; // zero outside read acks
  // level interrupt from sticky status under the mask
  // built from the four status and mask flops only, so it cannot glitch on bus inputs
  assign irq = |(status_reg & mask_reg);

endmodule

// ===== testbench/acw_top_sva.sv
// bus handshake and interrupt checks on the compare window block
// assumes a bind onto acw_top, one clock, synchronous low reset
`timescale 1ns/1ps
module acw_top_sva (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic conv_done,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////
  // bus answer timing, one pulse per request
  property p_ack_resp;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack missing");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
  property p_no_ack;
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
  endproperty
  a_no_ack: assert property (p_no_ack) else $error("stray ack");
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data idle");
  // unmapped read and untagged upper result bits read as zero
  property p_unmapped;
    wb_ack_o && !wb_we_i && wb_adr_i == 32'h4003_8100 |-> wb_dat_o == 0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped");
  property p_result_hi;
    wb_ack_o && !wb_we_i && wb_adr_i == 32'h4003_8020 |-> !(|wb_dat_o[31:16]);
  endproperty
  a_result_hi: assert property (p_result_hi) else $error("result");
  // irq moves only after a conversion or a bus access
  property p_irq_rise;
    $rose(irq) |-> $past(conv_done) || wb_ack_o;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rise");
  property p_irq_fall;
    $fell(irq) |-> wb_ack_o;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fall");
endmodule

// ===== testbench/adc_compare_window_config_tb_top.sv
// self-checking bench for the compare window block
// assumes acw_top with wishbone on ref_clk and a pulsed conversion input
`timescale 1ns/1ps
`include "acw_consts.svh"
module adc_compare_window_config_tb_top;
  logic ref_clk = 0, resetn = 0, cyc = 0, stb = 0, we = 0, done = 0, ack, irq;
  logic [31:0] adr = 0, wd = 0, rd;
  logic [3:0] ch = 0;
  logic [11:0] smp = 0;
  int err_count = 0, n_checks = 0;
  acw_top acw_top_i (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .conv_done(done),
    .conv_channel(ch), .conv_data(smp), .irq(irq));
  always #12.5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
    n = 0;
    do begin @(posedge ref_clk); n++; end while (ack !== 1'b1 && n < 20);
    q = rd;
    cyc <= 0;
    stb <= 0;
    if (ack !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED t=%0t ack=%h exp=1", $time, ack);
      test_done;
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask
  task automatic conv(input logic [3:0] c, input logic [11:0] v);
    @(posedge ref_clk);
    {done, ch, smp} <= {1'b1, c, v};
    @(posedge ref_clk);
    done <= 0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // every condition, window 0x100..0x200, all channels, select ignored
  task automatic t_modes;
    logic [11:0] v[5] = '{12'h0ff, 12'h100, 12'h150, 12'h200, 12'h201};
    logic h;
    wr(`ACW_WIN_ADDR, 32'h0200_0100);
    for (int m = 0; m < 4; m++) begin
      wr(`ACW_EMR_ADDR, 32'h0000_0200 | m);
      for (int i = 0; i < 5; i++) begin
        h = m == 0 ? v[i] < 12'h100 : m == 1 ? v[i] > 12'h200 :
            (v[i] >= 12'h100 && v[i] <= 12'h200) ^ (m == 3);
        conv(4'h7, v[i]);
        rdc(`ACW_ISR_ADDR, {30'h0, h, 1'b1});
      end
    end
  endtask
  // single selected channel, masked irq raised and read-cleared
  task automatic t_select;
    wr(`ACW_IMR_ADDR, 32'h0000_0002);
    wr(`ACW_EMR_ADDR, 32'h0000_0052);
    conv(4'h3, 12'h150);
    @(negedge ref_clk);
    chk(irq, 1'b0);
    rdc(`ACW_ISR_ADDR, 32'h0000_0001);
    conv(4'h5, 12'h150);
    @(negedge ref_clk);
    chk(irq, 1'b1);
    rdc(`ACW_ISR_ADDR, 32'h0000_0003);
    chk(irq, 1'b0);
  endtask
  // channel tag off then on
  task automatic t_tag;
    wr(`ACW_EMR_ADDR, 32'h0000_0000);
    conv(4'h9, 12'h0ab);
    rdc(`ACW_LCR_ADDR, 32'h0000_00ab);
    wr(`ACW_EMR_ADDR, 32'h0100_0000);
    conv(4'h9, 12'h0cd);
    rdc(`ACW_LCR_ADDR, 32'h0000_90cd);
  endtask
  // protected write dropped, then lands; unmapped read is zero
  task automatic t_wprot;
    wr(`ACW_WPR_ADDR, 32'h0000_0001);
    wr(`ACW_EMR_ADDR, 32'h0000_0003);
    rdc(`ACW_EMR_ADDR, 32'h0100_0000);
    wr(`ACW_WPR_ADDR, 32'h0000_0000);
    wr(`ACW_EMR_ADDR, 32'h0000_0003);
    rdc(`ACW_EMR_ADDR, 32'h0000_0003);
    rdc(32'h4003_8100, 32'h0000_0000);
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1;
    rdc(`ACW_EMR_ADDR, `ACW_EMR_RST);
    t_modes;
    t_select;
    t_tag;
    t_wprot;
    test_done;
  end
endmodule
bind acw_top acw_top_sva acw_top_sva_i (.ref_clk(ref_clk), .resetn(resetn),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .conv_done(conv_done), .irq(irq));
